/* File: rtl/cusb_pkg.sv */
// constants and types for the card interface selection block
package cusb_pkg;
    localparam int unsigned REF_CLK_HZ_DEF = 25000000;
    localparam int unsigned HIZ_DEADLINE_NS = 80000;
    localparam int unsigned LOW_HOLD_MS = 10;
    localparam logic [7:0] SWITCH_PROTOCOL_T = 8'h0f;
    localparam logic [7:0] SWITCH_PARAM_TWO = 8'hc0;
    // two synchroniser stages plus the pull-up's own cycle: a negative line
    // raised by the attach is only visible to the state machine after this
    localparam int unsigned ATTACH_SETTLE_CYCLES = 3;

    typedef enum logic [2:0]
    {
        CUSB_WAIT_SUPPLY = 3'b000,
        CUSB_MONITOR     = 3'b001,
        CUSB_ATTACHED    = 3'b010,
        CUSB_USB_SEL     = 3'b011,
        CUSB_LEGACY_SEL  = 3'b100,
        CUSB_ABORTED     = 3'b101
    } cusb_state_t;

    typedef enum logic [1:0]
    {
        CUSB_CMD_NONE   = 2'b00,
        CUSB_CMD_SWITCH = 2'b01,
        CUSB_CMD_OTHER  = 2'b10
    } cusb_cmd_t;

    // cycles for a time in nanoseconds, rounded down, at least one
    function automatic int unsigned cusb_cycles_floor(input int unsigned hz,
                                                      input int unsigned ns);
        longint unsigned c;
        c = (longint'(hz) * longint'(ns)) / 64'd1000000000;
        if (c == 0)
            c = 1;
        return int'(c);
    endfunction : cusb_cycles_floor

    // cycles for a time in milliseconds, rounded up, at least one
    function automatic int unsigned cusb_cycles_ceil_ms(input int unsigned hz,
                                                        input int unsigned ms);
        longint unsigned c;
        c = (longint'(hz) * longint'(ms) + 64'd999) / 64'd1000;
        if (c == 0)
            c = 1;
        return int'(c);
    endfunction : cusb_cycles_ceil_ms
endpackage : cusb_pkg

/* File: rtl/cusb_select.sv */
// start-up selection between legacy contact interface and chip link
`timescale 1ns/100ps
// Operation
// - both data contacts go high impedance within 80 us of stable supply.
// - attach only after 10 ms both-low hold, or after switch request.
// - attach pulls positive line high; negative high too aborts, pull-downs on.
// - card works with legacy clock stopped while reset contact is low.
// - on switch request attach before reply, stay attached through bus reset.
// - other command after reset answer: release lines, pull-downs, no reattach.
// - after switch exchange, legacy events and commands are ignored.
// - legacy command in progress completes despite a bus reset.
// - only one of legacy and USB interface is selected at a time.
// - USB selected on switch or configured; legacy on other command.
// - actions on one interface leave the other unchanged.
module cusb_select
    import cusb_pkg::*;
#(
    parameter int unsigned REF_CLK_HZ = REF_CLK_HZ_DEF,
    parameter int unsigned HIZ_CYCLES = cusb_cycles_floor(REF_CLK_HZ, HIZ_DEADLINE_NS),
    parameter int unsigned HOLD_CYCLES = cusb_cycles_ceil_ms(REF_CLK_HZ, LOW_HOLD_MS)
)
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       supply_stable,
    input  wire logic       usb_dplus_contact_in,
    input  wire logic       usb_dminus_contact_in,
    output logic            usb_dplus_contact_out,
    output logic            usb_dplus_contact_oe,
    output logic            usb_dminus_contact_out,
    output logic            usb_dminus_contact_oe,
    output logic            pulldown_en,
    input  wire logic       card_reset_contact,
    input  wire logic       legacy_cmd_valid,
    input  wire logic [7:0] legacy_cmd_protocol,
    input  wire logic [7:0] protocol_param_byte_two,
    input  wire logic       legacy_cmd_busy,
    output logic            legacy_cmd_accept,
    output logic            switch_reply_ready,
    input  wire logic       usb_bus_reset,
    input  wire logic       usb_configured,
    output logic            usb_connect_en,
    output logic            usb_selected,
    output logic            legacy_selected,
    output logic            hiz_done
);
    cusb_state_t state_r;
    cusb_state_t state_nxt;
    logic        pd_r;
    logic        pd_nxt;
    logic        sw_pend_r;
    logic        sw_pend_nxt;
    logic        hiz_r;
    logic        hiz_nxt;
    logic        dp_s;
    logic        dm_s;
    logic        hold_done;
    logic        hiz_tmo;
    logic        lines_low;
    cusb_cmd_t   cmd;
    logic [1:0]  settle_r;
    logic [1:0]  settle_nxt;
    logic        settled;
    logic [31:0] hiz_wait_r;
    logic [31:0] hiz_wait_nxt;

    // data contacts come from the far end, resync before use
    cusb_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({usb_dplus_contact_in, usb_dminus_contact_in}),
        .sync_out ({dp_s, dm_s})
    );

    assign lines_low = !dp_s && !dm_s;

    cusb_timer #(
        .TERMINAL (HOLD_CYCLES)
    ) u_hold (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (state_r == CUSB_MONITOR && lines_low),
        .done    (hold_done)
    );

    cusb_timer #(
        .TERMINAL (HIZ_CYCLES)
    ) u_hiz (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (supply_stable && !hiz_r),
        .done    (hiz_tmo)
    );

    // attach commits only after the negative line has come through the
    // synchroniser; leaving sooner would skip the abort check
    always_comb
    begin
        settle_nxt = '0;
        if (state_r == CUSB_ATTACHED)
        begin
            if (settled)
                settle_nxt = settle_r;
            else
                settle_nxt = settle_r + 2'h1;
        end
    end

    assign settled = (settle_r == 2'(ATTACH_SETTLE_CYCLES));

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            settle_r <= '0;
        else
            settle_r <= settle_nxt;
    end

    // release watchdog, cleared by supply loss or a finished release stage
    always_comb
    begin
        hiz_wait_nxt = hiz_wait_r;
        if (!supply_stable || hiz_r)
            hiz_wait_nxt = '0;
        else if (hiz_wait_r != '1)
            hiz_wait_nxt = hiz_wait_r + 32'h1;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            hiz_wait_r <= '0;
        else
            hiz_wait_r <= hiz_wait_nxt;
    end

    // legacy commands are ignored once USB owns the card; legacy stays usable
    // while the card reset contact is low and its clock is stopped
    always_comb
    begin
        cmd = CUSB_CMD_NONE;
        if (legacy_cmd_valid && state_r != CUSB_USB_SEL)
        begin
            if (legacy_cmd_protocol == SWITCH_PROTOCOL_T &&
                protocol_param_byte_two == SWITCH_PARAM_TWO)
                cmd = CUSB_CMD_SWITCH;
            else
                cmd = CUSB_CMD_OTHER;
        end
    end

    always_comb
    begin
        state_nxt   = state_r;
        pd_nxt      = pd_r;
        sw_pend_nxt = sw_pend_r;
        // lines are released once the stage timer reaches the HIZ_CYCLES deadline count
        hiz_nxt     = hiz_r || (supply_stable && hiz_tmo);
        case (state_r)
            CUSB_WAIT_SUPPLY:
            begin
                if (supply_stable)
                    state_nxt = CUSB_MONITOR;
            end
            CUSB_MONITOR:
            begin
                if (!supply_stable)
                    state_nxt = CUSB_WAIT_SUPPLY;
                else if (cmd == CUSB_CMD_SWITCH)
                begin
                    sw_pend_nxt = 1'b1;
                    state_nxt   = CUSB_ATTACHED;
                end
                else if (cmd == CUSB_CMD_OTHER)
                begin
                    pd_nxt    = 1'b1;
                    state_nxt = CUSB_LEGACY_SEL;
                end
                else if (hold_done)
                    state_nxt = CUSB_ATTACHED;
            end
            CUSB_ATTACHED:
            begin
                if (dm_s && !settled)
                begin
                    pd_nxt      = 1'b1;
                    sw_pend_nxt = 1'b0;
                    state_nxt   = CUSB_ABORTED;
                end
                else if (cmd == CUSB_CMD_OTHER && !sw_pend_r)
                begin
                    pd_nxt    = 1'b1;
                    state_nxt = CUSB_LEGACY_SEL;
                end
                else if (settled && (cmd == CUSB_CMD_SWITCH || sw_pend_r || usb_configured))
                begin
                    sw_pend_nxt = 1'b0;
                    state_nxt   = CUSB_USB_SEL;
                end
                else if (cmd == CUSB_CMD_SWITCH)
                    sw_pend_nxt = 1'b1;
            end
            CUSB_USB_SEL:
            begin
                // attachment holds; a bus reset does not detach
                state_nxt = CUSB_USB_SEL;
            end
            CUSB_LEGACY_SEL:
            begin
                state_nxt = CUSB_LEGACY_SEL;
            end
            CUSB_ABORTED:
            begin
                state_nxt = CUSB_ABORTED;
            end
            default:
            begin
                state_nxt = CUSB_WAIT_SUPPLY;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r   <= CUSB_WAIT_SUPPLY;
            pd_r      <= 1'b0;
            sw_pend_r <= 1'b0;
            hiz_r     <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            pd_r      <= pd_nxt;
            sw_pend_r <= sw_pend_nxt;
            hiz_r     <= hiz_nxt;
        end
    end

    // the card never drives the data lines itself here; attach is the
    // positive-line pull-up, handed to the phy as usb_connect_en
    assign usb_dplus_contact_out  = 1'b0;
    assign usb_dplus_contact_oe   = 1'b0;
    assign usb_dminus_contact_out = 1'b0;
    assign usb_dminus_contact_oe  = 1'b0;
    assign pulldown_en            = pd_r;
    assign usb_connect_en = (state_r == CUSB_ATTACHED || state_r == CUSB_USB_SEL);
    assign usb_selected    = (state_r == CUSB_USB_SEL);
    assign legacy_selected = (state_r == CUSB_LEGACY_SEL);
    assign hiz_done        = hiz_r;
    // reply to switch only once attached
    assign switch_reply_ready = (state_r == CUSB_ATTACHED && sw_pend_r);
    // a busy legacy command is allowed to finish regardless of bus reset
    assign legacy_cmd_accept = (state_r != CUSB_USB_SEL) || legacy_cmd_busy;

    hold_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(usb_connect_en) && !$past(sw_pend_nxt) |-> $past(hold_done))
        else $error("attach without low hold or switch");
    abort_pd_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_r == CUSB_ATTACHED && dm_s && !settled |=> pulldown_en && !usb_connect_en)
        else $error("negative line high did not abort attach");
    no_reattach_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        legacy_selected |=> legacy_selected && !usb_connect_en && pulldown_en)
        else $error("reattach after legacy selection");
    exclusive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(usb_selected && legacy_selected))
        else $error("both interfaces selected");
    stay_usb_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        usb_selected ##1 usb_bus_reset |-> usb_connect_en)
        else $error("detached on bus reset");
    hiz_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        hiz_wait_r <= HIZ_CYCLES + 1)
        else $error("high impedance deadline missed");
    switch_attach_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_r == CUSB_MONITOR && cmd == CUSB_CMD_SWITCH && supply_stable
        |=> usb_connect_en && switch_reply_ready)
        else $error("switch request did not attach first");
    usb_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        usb_selected && legacy_cmd_valid |=> usb_selected && !legacy_selected)
        else $error("legacy command seen after switch");
    commit_settle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(usb_selected) |-> $past(settled))
        else $error("attach committed before negative line was checked");
    other_legacy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_r == CUSB_MONITOR && supply_stable && cmd == CUSB_CMD_OTHER
        |=> legacy_selected && pulldown_en && !usb_connect_en)
        else $error("other command did not select legacy");
    hiz_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        hiz_done |=> hiz_done && !usb_dplus_contact_oe && !usb_dminus_contact_oe)
        else $error("data contacts driven after release");
endmodule : cusb_select

/* File: rtl/cusb_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cusb_sync2
    import cusb_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : cusb_sync2

/* File: rtl/cusb_timer.sv */
// saturating cycle counter that flags when a terminal count is reached
`timescale 1ns/100ps
module cusb_timer
    import cusb_pkg::*;
#(
    parameter int unsigned TERMINAL = 16,
    parameter int unsigned WIDTH    = $clog2(TERMINAL + 1)
)
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      done
);
    localparam logic [WIDTH-1:0] TERM_C = WIDTH'(TERMINAL);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // dropping run restarts the count from zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (!run)
            cnt_nxt = '0;
        else if (cnt_r != TERM_C)
            cnt_nxt = cnt_r + WIDTH'(1);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign done = run && (cnt_r == TERM_C);
endmodule : cusb_timer

/* File: verif/card_usb_interface_selection_bench.sv */
// self-checking bench for the card interface selection block
`timescale 1ns/100ps
module card_usb_interface_selection_bench;
    import cusb_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned HIZ  = 5;
    logic       ref_clk;
    logic       rstn;
    logic       supply_stable;
    logic       legacy_cmd_valid;
    logic [7:0] legacy_cmd_protocol;
    logic [7:0] protocol_param_byte_two;
    logic       legacy_cmd_busy;
    logic       usb_configured;
    logic       short_dm;
    logic       bus_reset_en;
    wire logic  usb_dplus_contact_in, usb_dminus_contact_in, usb_dplus_contact_out;
    wire logic  usb_dplus_contact_oe, usb_dminus_contact_out, usb_dminus_contact_oe;
    wire logic  pulldown_en, card_reset_contact, legacy_cmd_accept, switch_reply_ready;
    wire logic  usb_bus_reset, usb_connect_en, usb_selected, legacy_selected, hiz_done;
    int         err_count;
    int         total_checks;
    int         cycles;

    cusb_select #(.HIZ_CYCLES(HIZ), .HOLD_CYCLES(HOLD)) i_dut (.ref_clk, .rstn,
        .supply_stable, .usb_dplus_contact_in, .usb_dminus_contact_in,
        .usb_dplus_contact_out, .usb_dplus_contact_oe, .usb_dminus_contact_out,
        .usb_dminus_contact_oe, .pulldown_en, .card_reset_contact, .legacy_cmd_valid,
        .legacy_cmd_protocol, .protocol_param_byte_two, .legacy_cmd_busy,
        .legacy_cmd_accept, .switch_reply_ready, .usb_bus_reset, .usb_configured,
        .usb_connect_en, .usb_selected, .legacy_selected, .hiz_done);

    cusb_term_model i_term (.ref_clk, .rstn, .usb_connect_en, .usb_dplus_contact_out,
        .usb_dplus_contact_oe, .usb_dminus_contact_out, .usb_dminus_contact_oe,
        .short_dm, .bus_reset_en, .usb_dplus_contact_in, .usb_dminus_contact_in,
        .card_reset_contact, .usb_bus_reset);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // run length is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles >= 3000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    task automatic watch(input int limit, output int t_hiz, output int t_con);
        t_hiz = -1;
        t_con = -1;
        for (int i = 1; i <= limit; i++)
        begin
            @(negedge ref_clk);
            if (t_hiz < 0 && hiz_done === 1'b1)
                t_hiz = i;
            if (t_con < 0 && usb_connect_en === 1'b1)
                t_con = i;
        end
    endtask : watch

    // power cycle: reset for three cycles, then a stable supply
    task automatic power_up();
        @(negedge ref_clk);
        rstn = 1'b0;
        supply_stable = 1'b0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        check("dplus_oe", usb_dplus_contact_oe, 1'b0);
        check("dminus_oe", usb_dminus_contact_oe, 1'b0);
        check("connect_idle", usb_connect_en, 1'b0);
        check("dplus_out", usb_dplus_contact_out, 1'b0);
        check("dminus_out", usb_dminus_contact_out, 1'b0);
        supply_stable = 1'b1;
    endtask : power_up

    task automatic send_cmd(input logic [7:0] proto, input logic [7:0] two);
        legacy_cmd_valid = 1'b1;
        legacy_cmd_protocol = proto;
        protocol_param_byte_two = two;
        @(negedge ref_clk);
        legacy_cmd_valid = 1'b0;
    endtask : send_cmd

    task automatic test_hold();
        int th;
        int tc;
        power_up();
        watch(HOLD + 10, th, tc);
        check("hiz_in_time", th > 0 && th <= HIZ + 3, 1'b1);
        check("no_early_attach", tc >= HOLD, 1'b1);
        check("attach_in_time", tc > 0 && tc <= HOLD + 6, 1'b1);
        usb_configured = 1'b1;
        @(negedge ref_clk);
        check("usb_sel_cfg", usb_selected, 1'b1);
        check("legacy_off_cfg", legacy_selected, 1'b0);
        send_cmd(8'h11, 8'h00);
        check("legacy_ignored", legacy_selected, 1'b0);
        check("usb_kept", usb_selected, 1'b1);
        check("still_attached", usb_connect_en, 1'b1);
        usb_configured = 1'b0;
        $display("test_hold done");
    endtask : test_hold

    task automatic test_switch();
        power_up();
        repeat (3) @(negedge ref_clk);
        legacy_cmd_busy = 1'b1;
        send_cmd(SWITCH_PROTOCOL_T, SWITCH_PARAM_TWO);
        check("attach_on_switch", usb_connect_en, 1'b1);
        check("reply_after_attach", switch_reply_ready, 1'b1);
        // usb is committed only once the negative line has been checked
        repeat (ATTACH_SETTLE_CYCLES + 1) @(negedge ref_clk);
        check("usb_sel_switch", usb_selected, 1'b1);
        check("legacy_off_switch", legacy_selected, 1'b0);
        check("busy_completes", legacy_cmd_accept, 1'b1);
        legacy_cmd_busy = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("legacy_shut", legacy_cmd_accept, 1'b0);
        check("attached_after_reset", usb_connect_en, 1'b1);
        send_cmd(8'h11, 8'h00);
        check("late_cmd_ignored", legacy_selected, 1'b0);
        check("usb_after_cmd", usb_selected, 1'b1);
        $display("test_switch done");
    endtask : test_switch

    task automatic test_other();
        int th;
        int tc;
        power_up();
        @(negedge ref_clk);
        // right protocol but wrong second byte is not the switch request
        send_cmd(SWITCH_PROTOCOL_T, 8'h00);
        check("legacy_sel", legacy_selected, 1'b1);
        check("usb_off", usb_selected, 1'b0);
        check("pulldowns_on", pulldown_en, 1'b1);
        check("no_connect", usb_connect_en, 1'b0);
        watch(HOLD + 10, th, tc);
        check("no_reattach", tc < 0, 1'b1);
        send_cmd(SWITCH_PROTOCOL_T, SWITCH_PARAM_TWO);
        check("switch_refused", usb_connect_en, 1'b0);
        check("legacy_kept", legacy_selected, 1'b1);
        $display("test_other done");
    endtask : test_other

    task automatic test_abort();
        int th;
        int tc;
        short_dm = 1'b1;
        power_up();
        watch(HOLD + 15, th, tc);
        check("attach_tried", tc > 0, 1'b1);
        check("attach_aborted", usb_connect_en, 1'b0);
        check("abort_pulldowns", pulldown_en, 1'b1);
        short_dm = 1'b0;
        $display("test_abort done");
    endtask : test_abort

    // supply withdrawn, power cycled until reattached, then legacy fallback
    task automatic test_retry();
        int th;
        int tc;
        power_up();
        repeat (3) @(negedge ref_clk);
        supply_stable = 1'b0;
        watch(HOLD + 10, th, tc);
        check("no_attach_unpowered", tc < 0, 1'b1);
        repeat (3)
        begin
            power_up();
            repeat (4) @(negedge ref_clk);
        end
        check("monitor_no_attach", usb_connect_en, 1'b0);
        power_up();
        watch(HOLD + 10, th, tc);
        check("reattach_after_cycle", tc > 0, 1'b1);
        power_up();
        @(negedge ref_clk);
        send_cmd(8'h11, 8'h00);
        check("legacy_after_cycle", legacy_selected, 1'b1);
        check("pulldowns_after_cycle", pulldown_en, 1'b1);
        $display("test_retry done");
    endtask : test_retry

    initial
    begin
        rstn = 1'b0;
        supply_stable = 1'b0;
        legacy_cmd_valid = 1'b0;
        legacy_cmd_protocol = 8'h00;
        protocol_param_byte_two = 8'h00;
        legacy_cmd_busy = 1'b0;
        usb_configured = 1'b0;
        short_dm = 1'b0;
        bus_reset_en = 1'b1;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        test_hold();
        test_switch();
        test_other();
        test_abort();
        test_retry();
        end_sim();
    end
endmodule : card_usb_interface_selection_bench

/* File: verif/cusb_term_model.sv */
// terminal side model: pull-downs, card reset held low, bus reset on attach
`timescale 1ns/100ps
module cusb_term_model
    import cusb_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic usb_connect_en,
    input  wire logic usb_dplus_contact_out,
    input  wire logic usb_dplus_contact_oe,
    input  wire logic usb_dminus_contact_out,
    input  wire logic usb_dminus_contact_oe,
    input  wire logic short_dm,
    input  wire logic bus_reset_en,
    output logic      usb_dplus_contact_in,
    output logic      usb_dminus_contact_in,
    output logic      card_reset_contact,
    output logic      usb_bus_reset
);
    logic [1:0] seen_r;
    logic [1:0] seen_nxt;

    always_comb
    begin
        // terminal pull-downs win unless the card pulls up or drives
        usb_dplus_contact_in = (usb_dplus_contact_oe & usb_dplus_contact_out)
                               | usb_connect_en;
        // short_dm models a faulty terminal that drags the negative line up too
        usb_dminus_contact_in = (usb_dminus_contact_oe & usb_dminus_contact_out)
                                | (short_dm & usb_dplus_contact_in);
        // legacy clock never runs here, so reset must stay low
        card_reset_contact = 1'b0;
        seen_nxt = {seen_r[0], usb_dplus_contact_in};
        usb_bus_reset = bus_reset_en & seen_r[1] & seen_r[0];
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            seen_r <= 2'h0;
        else
            seen_r <= seen_nxt;
    end
endmodule : cusb_term_model
